// [tsc_ctrl.v]
`timescale 1ns/1ps
`include "tsc_regs.vh"
// How it works
// - enable bit turns sequencer on; cleared keeps it disabled.
// - idle-halt set stops operation during Idle; clear keeps running.
// - toggle set inverts trigger per trigger command; clear gives one pulse.
// - software trigger completes a wait-for-software-trigger step, options 1010/1011.
// - writing zero to software trigger only clears it; hardware clears too.
// - software trigger affects only the control step's software-wait option.
// - single-step set in Debug runs one step at a time.
// - single-step bit is writable only while in Debug mode.
// - visibility set makes limit registers read live counter values.
// - visibility clear makes limit registers read programmed limits.
// - start bit begins continuous execution; hardware may clear it.
// - clearing start stops execution of further steps.
// - hardware sets watchdog time-out flag on watchdog expiry.
// - input-trigger mode only affects wait-input-high and wait-input-low.
// - bits 14, 11, 4..2 read zero; implemented bits reset to zero.
// - busy reads one while running; clock and divider writes blocked.
// - mode codes: 0x edge, 1x level; odd codes skip step delay.
module tsc_ctrl
(
    input  wire        MCLK,
    input  wire        ARST_N,
    input  wire [3:0]  ADDR,
    input  wire [15:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [15:0] RDATA,
    output reg         IRQ,
    input  wire        DEVICE_IDLE,
    input  wire        DEVICE_DEBUG,
    input  wire        STEP_DONE,
    input  wire        STEP_IS_SWT_WAIT,
    input  wire [3:0]  STEP_OPTION,
    input  wire        STEP_IS_WAIT_INPUT,
    input  wire        STEP_IS_TRIGGER_OUTPUT,
    input  wire        QUEUE_STOP,
    input  wire        WATCHDOG_EXPIRED,
    input  wire        CLK_CFG_WR_REQ,
    input  wire [15:0] SDLY_LIVE,
    input  wire [15:0] LCNT0_LIVE,
    input  wire [15:0] LCNT1_LIVE,
    input  wire [15:0] GTMR0_LIVE,
    input  wire [15:0] GTMR1_LIVE,
    output reg         STEP_ADVANCE,
    output reg         SWT_COMPLETE,
    output reg         TRIGGER_OUTPUT,
    output reg  [1:0]  INPUT_TRIGGER_MODE,
    output reg         ITM_LEVEL_DETECT,
    output reg         ITM_SKIP_STEP_DELAY,
    output reg         CLK_CFG_WR_ALLOW,
    output reg         SEQUENCER_BUSY
);

    // =================================================================
    // control and limit storage
    reg        seq_enable_q;
    reg        idle_halt_q;
    reg        trigger_toggle_select_q;
    reg        software_trigger_q;
    reg        single_step_enable_q;
    reg        counter_visibility_q;
    reg        sequencer_start_q;
    reg        watchdog_timeout_flag_q;
    reg        busy_q;
    reg [1:0]  input_trigger_mode_q;
    reg [1:0]  irq_stat_q;
    reg [1:0]  irq_mask_q;
    reg        ss_armed_q;
    reg [15:0] lim_q [0:4];

    wire wr_cst   = WR && (ADDR == `TSC_ADDR_CST);
    wire wr_stat  = WR && (ADDR == `TSC_ADDR_IRQ_STAT);
    wire wr_mask  = WR && (ADDR == `TSC_ADDR_IRQ_MASK);
    wire wr_debug = WR && (ADDR == `TSC_ADDR_DEBUG);

    // halted during idle, or stopped by enable/start
    wire running  = seq_enable_q && sequencer_start_q && !(idle_halt_q && DEVICE_IDLE);
    // single step: one step per arm while in Debug
    wire ss_mode  = single_step_enable_q && DEVICE_DEBUG;
    wire may_step = running && (!ss_mode || ss_armed_q);

    // swt only completes the control step's software-wait options
    wire swt_hit  = software_trigger_q && STEP_IS_SWT_WAIT &&
                    ((STEP_OPTION == `TSC_OPT_SWT_A) || (STEP_OPTION == `TSC_OPT_SWT_B));

    wire trigger_output_evt = may_step && STEP_IS_TRIGGER_OUTPUT && STEP_DONE;

    // =================================================================
    // functions
    function is_lim_addr;
        input [3:0] a;
        begin
            is_lim_addr = (a >= `TSC_ADDR_SDLY) && (a <= `TSC_ADDR_GTMR1);
        end
    endfunction

    function [2:0] lim_index;
        input [3:0] a;
        begin
            lim_index = a[2:0] - 3'h3;
        end
    endfunction

    // =================================================================
    // control/status register
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            seq_enable_q            <= 1'b0;
            idle_halt_q             <= 1'b0;
            trigger_toggle_select_q <= 1'b0;
            software_trigger_q      <= 1'b0;
            single_step_enable_q    <= 1'b0;
            counter_visibility_q    <= 1'b0;
            sequencer_start_q       <= 1'b0;
            watchdog_timeout_flag_q <= 1'b0;
            busy_q                  <= 1'b0;
            input_trigger_mode_q    <= 2'h0;
            ss_armed_q              <= 1'b0;
        end
        else
        begin
            // plain fields follow the write as given
            if (wr_cst)
            begin
                seq_enable_q            <= WDATA[`TSC_BIT_EN];
                idle_halt_q             <= WDATA[`TSC_BIT_IDLE_HALT];
                trigger_toggle_select_q <= WDATA[`TSC_BIT_TOGGLE];
                counter_visibility_q    <= WDATA[`TSC_BIT_VIS];
                input_trigger_mode_q    <= WDATA[`TSC_ITM_HI:`TSC_ITM_LO];
            end

            // single step only moves while the device is in Debug
            if (wr_cst && DEVICE_DEBUG)
            begin
                single_step_enable_q <= WDATA[`TSC_BIT_SSEN];
            end

            // software trigger: write one sets, write zero clears, hardware clears on use
            if (wr_cst)
            begin
                software_trigger_q <= WDATA[`TSC_BIT_SWT];
            end
            else if (swt_hit && may_step)
            begin
                software_trigger_q <= 1'b0;
            end

            // start: hardware clears at queue stop or disable
            if (wr_cst && !(WDATA[`TSC_BIT_EN] == 1'b0))
            begin
                sequencer_start_q <= WDATA[`TSC_BIT_START];
            end
            else if (wr_cst || !seq_enable_q || (QUEUE_STOP && running))
            begin
                sequencer_start_q <= 1'b0;
            end

            // watchdog flag: hardware set wins over software clear
            if (WATCHDOG_EXPIRED && running)
            begin
                watchdog_timeout_flag_q <= 1'b1;
            end
            else if (wr_cst && !WDATA[`TSC_BIT_WDTO])
            begin
                watchdog_timeout_flag_q <= 1'b0;
            end

            // busy lags running by one cycle, so a read just after a stop may still show it
            busy_q <= running && !(wr_cst && !WDATA[`TSC_BIT_EN]);

            // debugger re-arms one step through the debug register
            if (wr_debug && DEVICE_DEBUG)
            begin
                ss_armed_q <= 1'b1;
            end
            else if (ss_mode && STEP_DONE && may_step)
            begin
                ss_armed_q <= 1'b0;
            end
        end
    end

    // =================================================================
    // limit registers, written whenever visibility is clear or set
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1)
        begin : g_lim
            always @(posedge MCLK or negedge ARST_N)
            begin
                if (!ARST_N)
                begin
                    lim_q[g] <= `TSC_LIM_RESET;
                end
                else if (WR && is_lim_addr(ADDR) && (lim_index(ADDR) == g))
                begin
                    lim_q[g] <= WDATA;
                end
            end
        end
    endgenerate

    // =================================================================
    // interrupts: sticky status, write one to clear, set wins
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            irq_stat_q <= `TSC_IRQ_RESET;
        end
        else
        begin
            irq_stat_q[`TSC_IRQ_WDTO] <= (WATCHDOG_EXPIRED && running) ||
                (irq_stat_q[`TSC_IRQ_WDTO] && !(wr_stat && WDATA[`TSC_IRQ_WDTO]));
            irq_stat_q[`TSC_IRQ_TRIGGER_OUTPUT] <= trigger_output_evt ||
                (irq_stat_q[`TSC_IRQ_TRIGGER_OUTPUT] && !(wr_stat && WDATA[`TSC_IRQ_TRIGGER_OUTPUT]));
        end
    end

    // mask is plain software state, kept apart from the status flops
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            irq_mask_q <= `TSC_IRQ_RESET;
        end
        else if (wr_mask)
        begin
            irq_mask_q <= WDATA[1:0];
        end
    end

    // =================================================================
    // live values versus programmed limits
    reg [15:0] live_sel;
    always @*
    begin
        live_sel = 16'h0000;
        if (ADDR == `TSC_ADDR_SDLY)
        begin
            live_sel = SDLY_LIVE;
        end
        else if (ADDR == `TSC_ADDR_LCNT0)
        begin
            live_sel = LCNT0_LIVE;
        end
        else if (ADDR == `TSC_ADDR_LCNT1)
        begin
            live_sel = LCNT1_LIVE;
        end
        else if (ADDR == `TSC_ADDR_GTMR0)
        begin
            live_sel = GTMR0_LIVE;
        end
        else if (ADDR == `TSC_ADDR_GTMR1)
        begin
            live_sel = GTMR1_LIVE;
        end
    end

    reg [15:0] rd_d;
    always @*
    begin
        rd_d = 16'h0000;
        if (ADDR == `TSC_ADDR_CST)
        begin
            rd_d[`TSC_BIT_EN]        = seq_enable_q;
            rd_d[`TSC_BIT_IDLE_HALT] = idle_halt_q;
            rd_d[`TSC_BIT_TOGGLE]    = trigger_toggle_select_q;
            rd_d[`TSC_BIT_SWT]       = software_trigger_q;
            rd_d[`TSC_BIT_SSEN]      = single_step_enable_q;
            rd_d[`TSC_BIT_VIS]       = counter_visibility_q;
            rd_d[`TSC_BIT_START]     = sequencer_start_q;
            rd_d[`TSC_BIT_WDTO]      = watchdog_timeout_flag_q;
            rd_d[`TSC_BIT_BUSY]      = busy_q;
            rd_d[`TSC_ITM_HI:`TSC_ITM_LO] = input_trigger_mode_q;
        end
        else if (ADDR == `TSC_ADDR_IRQ_STAT)
        begin
            rd_d = {14'h0000, irq_stat_q};
        end
        else if (ADDR == `TSC_ADDR_IRQ_MASK)
        begin
            rd_d = {14'h0000, irq_mask_q};
        end
        else if (is_lim_addr(ADDR))
        begin
            rd_d = counter_visibility_q ? live_sel : lim_q[lim_index(ADDR)];
        end
        else if (ADDR == `TSC_ADDR_DEBUG)
        begin
            rd_d = {15'h0000, ss_armed_q};
        end
    end

    // =================================================================
    // registered outputs, one flop per port so the far side never sees decode glitches
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            RDATA <= 16'h0000;
            IRQ   <= 1'b0;
        end
        else
        begin
            RDATA <= RD ? rd_d : 16'h0000;
            IRQ   <= |(irq_stat_q & irq_mask_q);
        end
    end

    // step engine handshake
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            STEP_ADVANCE <= 1'b0;
            SWT_COMPLETE <= 1'b0;
        end
        else
        begin
            STEP_ADVANCE <= may_step;
            SWT_COMPLETE <= swt_hit && may_step;
        end
    end

    // trigger output
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            TRIGGER_OUTPUT <= 1'b0;
        end
        else
        begin
            // toggle mode inverts per trigger step; pulse mode is one cycle wide
            if (!seq_enable_q)
            begin
                TRIGGER_OUTPUT <= 1'b0;
            end
            else if (trigger_toggle_select_q)
            begin
                TRIGGER_OUTPUT <= TRIGGER_OUTPUT ^ trigger_output_evt;
            end
            else
            begin
                TRIGGER_OUTPUT <= trigger_output_evt;
            end
        end
    end

    // mode decode and clock configuration guard
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            INPUT_TRIGGER_MODE  <= 2'h0;
            ITM_LEVEL_DETECT    <= 1'b0;
            ITM_SKIP_STEP_DELAY <= 1'b0;
            CLK_CFG_WR_ALLOW    <= 1'b0;
            SEQUENCER_BUSY      <= 1'b0;
        end
        else
        begin
            // mode only presented to the wait-input steps
            INPUT_TRIGGER_MODE  <= STEP_IS_WAIT_INPUT ? input_trigger_mode_q : 2'h0;
            ITM_LEVEL_DETECT    <= STEP_IS_WAIT_INPUT && input_trigger_mode_q[1];
            ITM_SKIP_STEP_DELAY <= STEP_IS_WAIT_INPUT && input_trigger_mode_q[0];
            // busy blocks the clock source and divider fields
            CLK_CFG_WR_ALLOW    <= CLK_CFG_WR_REQ && !busy_q;
            SEQUENCER_BUSY      <= busy_q;
        end
    end

endmodule

// [tsc_ctrl_monitor.sv]
`timescale 1ns/1ps
// ==========
// port-level checks of the control/status block
module tsc_ctrl_monitor
(
    input wire        MCLK,
    input wire        ARST_N,
    input wire [3:0]  ADDR,
    input wire        RD,
    input wire [15:0] RDATA,
    input wire        STEP_DONE,
    input wire        STEP_IS_TRIGGER_OUTPUT,
    input wire        STEP_IS_SWT_WAIT,
    input wire [3:0]  STEP_OPTION,
    input wire        STEP_IS_WAIT_INPUT,
    input wire        CLK_CFG_WR_REQ,
    input wire        STEP_ADVANCE,
    input wire        SWT_COMPLETE,
    input wire        TRIGGER_OUTPUT,
    input wire [1:0]  INPUT_TRIGGER_MODE,
    input wire        ITM_LEVEL_DETECT,
    input wire        ITM_SKIP_STEP_DELAY,
    input wire        CLK_CFG_WR_ALLOW,
    input wire        SEQUENCER_BUSY
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("read data outside its slot");
    unmapped_zero_a: assert property ($past(RD) && $past(ADDR) > 4'h8 |-> RDATA == 16'h0000)
        else $error("unmapped read not zero");
    trigger_output_cause_a: assert property ($rose(TRIGGER_OUTPUT) |-> $past(STEP_DONE && STEP_IS_TRIGGER_OUTPUT))
        else $error("trigger without trigger step");
    swt_cause_a: assert property (SWT_COMPLETE |-> $past(STEP_IS_SWT_WAIT) &&
        ($past(STEP_OPTION) == 4'ha || $past(STEP_OPTION) == 4'hb)) else $error("software wait done wrongly");
    itm_fields_a: assert property (ITM_LEVEL_DETECT == INPUT_TRIGGER_MODE[1]
        && ITM_SKIP_STEP_DELAY == INPUT_TRIGGER_MODE[0]) else $error("mode decode wrong");
    itm_gate_a: assert property (!$past(STEP_IS_WAIT_INPUT) |-> INPUT_TRIGGER_MODE == 2'h0)
        else $error("mode shown outside wait step");
    cfg_cause_a: assert property (CLK_CFG_WR_ALLOW |-> $past(CLK_CFG_WR_REQ))
        else $error("grant without request");
    cfg_block_a: assert property (SEQUENCER_BUSY ##1 (SEQUENCER_BUSY && CLK_CFG_WR_REQ)
        ##1 SEQUENCER_BUSY |-> !CLK_CFG_WR_ALLOW) else $error("clock write granted while busy");
    step_busy_a: assert property (STEP_ADVANCE |-> ##[0:2] SEQUENCER_BUSY)
        else $error("stepping while not busy");
    cover property (SWT_COMPLETE);
    cover property ($rose(TRIGGER_OUTPUT));
    cover property (CLK_CFG_WR_ALLOW);
endmodule
bind tsc_ctrl tsc_ctrl_monitor mon (.MCLK(MCLK), .ARST_N(ARST_N), .ADDR(ADDR), .RD(RD), .RDATA(RDATA),
    .STEP_DONE(STEP_DONE), .STEP_IS_TRIGGER_OUTPUT(STEP_IS_TRIGGER_OUTPUT), .STEP_IS_SWT_WAIT(STEP_IS_SWT_WAIT),
    .STEP_OPTION(STEP_OPTION), .STEP_IS_WAIT_INPUT(STEP_IS_WAIT_INPUT), .CLK_CFG_WR_REQ(CLK_CFG_WR_REQ),
    .STEP_ADVANCE(STEP_ADVANCE), .SWT_COMPLETE(SWT_COMPLETE), .TRIGGER_OUTPUT(TRIGGER_OUTPUT),
    .INPUT_TRIGGER_MODE(INPUT_TRIGGER_MODE), .ITM_LEVEL_DETECT(ITM_LEVEL_DETECT),
    .ITM_SKIP_STEP_DELAY(ITM_SKIP_STEP_DELAY), .CLK_CFG_WR_ALLOW(CLK_CFG_WR_ALLOW),
    .SEQUENCER_BUSY(SEQUENCER_BUSY));

// [tsc_ctrl_test.sv]
`timescale 1ns/1ps
// ==========
// register table and step scenarios
module tsc_ctrl_test;
    localparam [15:0] BASE = 16'h5a00;
    reg         clk = 1'b0, arst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, idle = 1'b0, dbg = 1'b0, go = 1'b0, seen;
    reg  [1:0]  kind = 2'h0;
    reg  [2:0]  pul = 3'h0;
    reg  [3:0]  addr = 4'h0, opt = 4'h0;
    reg  [15:0] wdata = 16'h0000;
    reg  [35:0] rows [0:10];
    wire [15:0] rdata;
    wire [79:0] live;
    wire [1:0]  ev, itm;
    wire        irq, done, t_trigger_output, t_swt, t_winp, adv, swtc, trigger_output, lvl, skip, allow, busy;
    wire [4:0]  obs = {allow, irq, adv, swtc, trigger_output};
    integer     miscompares = 0, comparisons = 0, nsteps = 0, i;
    always #5 clk = ~clk;
    tsc_engine_model #(.BASE(BASE)) eng (.clk(clk), .arst_n(arst_n), .kind(kind), .go(go), .pl(pul[1:0]),
        .advance(adv), .done_q(done), .ev_q(ev), .is_trigger_output(t_trigger_output), .is_swt(t_swt), .is_winp(t_winp), .live(live));
    tsc_ctrl uut (.MCLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
        .IRQ(irq), .DEVICE_IDLE(idle), .DEVICE_DEBUG(dbg), .STEP_DONE(done), .STEP_IS_SWT_WAIT(t_swt),
        .STEP_OPTION(opt), .STEP_IS_WAIT_INPUT(t_winp), .STEP_IS_TRIGGER_OUTPUT(t_trigger_output), .QUEUE_STOP(ev[1]),
        .WATCHDOG_EXPIRED(ev[0]), .CLK_CFG_WR_REQ(pul[2]), .SDLY_LIVE(live[15:0]), .LCNT0_LIVE(live[31:16]),
        .LCNT1_LIVE(live[47:32]), .GTMR0_LIVE(live[63:48]), .GTMR1_LIVE(live[79:64]), .STEP_ADVANCE(adv),
        .SWT_COMPLETE(swtc), .TRIGGER_OUTPUT(trigger_output), .INPUT_TRIGGER_MODE(itm), .ITM_LEVEL_DETECT(lvl),
        .ITM_SKIP_STEP_DELAY(skip), .CLK_CFG_WR_ALLOW(allow), .SEQUENCER_BUSY(busy));
    task report_and_stop;
    begin
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    task chk(input string nm, input [15:0] seen_v, input [15:0] exp_v);
    begin
        comparisons = comparisons + 1;
        if (seen_v !== exp_v)
        begin
            miscompares = miscompares + 1;
            $display("Error %s expected %h seen %h", nm, exp_v, seen_v);
        end
    end
    endtask
    task wr(input [3:0] a, input [15:0] d);
    begin
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    end
    endtask
    task rd(input [3:0] a, input [15:0] e, input string nm);
    begin
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(nm, rdata, e);
    end
    endtask
    // bounded wait; running out of cycles ends the run
    task wt(input integer k, input v);
        integer n;
    begin
        n = 0;
        @(posedge clk);
        #1;
        while (obs[k] !== v && n < 8)
        begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        chk("port wait", {15'h0, obs[k]}, {15'h0, v});
        if (obs[k] !== v)
            report_and_stop;
    end
    endtask
    task step(input [1:0] k);
    begin
        @(posedge clk);
        kind <= k;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        #1;
        if (done === 1'b1)
            nsteps = nsteps + 1;
    end
    endtask
    task pulse(input integer k);
    begin
        @(posedge clk);
        pul[k] <= 1'b1;
        @(posedge clk);
        pul[k] <= 1'b0;
        #1;
    end
    endtask
    initial
    begin
        rows[0] = {4'h0, 16'h0000, 16'h0000};
        rows[1] = {4'h0, 16'hfbff, 16'hb1a3};
        rows[2] = {4'h0, 16'h0000, 16'h0000};
        rows[3] = {4'h3, 16'h1234, 16'h1234};
        rows[4] = {4'h4, 16'h2345, 16'h2345};
        rows[5] = {4'h5, 16'h3456, 16'h3456};
        rows[6] = {4'h6, 16'h4567, 16'h4567};
        rows[7] = {4'h7, 16'hffff, 16'hffff};
        rows[8] = {4'h2, 16'hffff, 16'h0003};
        rows[9] = {4'h2, 16'h0000, 16'h0000};
        rows[10] = {4'h9, 16'hffff, 16'h0000};
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        for (i = 0; i < 9; i = i + 1)
            rd(i[3:0], 16'h0000, "reset value");
        for (i = 0; i < 11; i = i + 1)
        begin
            wr(rows[i][35:32], rows[i][31:16]);
            rd(rows[i][35:32], rows[i][15:0], "register row");
        end
        wr(4'h0, 16'h8080);
        step(2'h1);
        wt(0, 1'b1);
        @(posedge clk);
        #1;
        chk("trigger pulse", {15'h0, trigger_output}, 16'h0000);
        wr(4'h0, 16'h9080);
        step(2'h1);
        wt(0, 1'b1);
        step(2'h1);
        wt(0, 1'b0);
        wr(4'h0, 16'ha080);
        idle <= 1'b1;
        wt(2, 1'b0);
        wr(4'h0, 16'h8080);
        wt(2, 1'b1);
        idle <= 1'b0;
        pulse(2);
        chk("clock grant busy", {15'h0, allow}, 16'h0000);
        pulse(1);
        @(posedge clk);
        rd(4'h0, 16'h8000, "hardware stop");
        pulse(2);
        chk("clock grant idle", {15'h0, allow}, 16'h0001);
        wr(4'h0, 16'h8080);
        wr(4'h1, 16'h0003);
        pulse(0);
        rd(4'h1, 16'h0001, "watchdog event");
        chk("masked irq", {15'h0, irq}, 16'h0000);
        wr(4'h2, 16'h0001);
        wt(3, 1'b1);
        wr(4'h1, 16'h0001);
        wt(3, 1'b0);
        for (i = 0; i < 3; i = i + 1)
        begin
            opt <= (i == 2) ? 4'h3 : 4'ha + i[3:0];
            kind <= 2'h2;
            wr(4'h0, 16'h8080);
            wr(4'h0, 16'h8480);
            seen = 1'b0;
            repeat (4) @(posedge clk) seen = seen | swtc;
            chk("software wait", {15'h0, seen}, (i < 2) ? 16'h0001 : 16'h0000);
        end
        wr(4'h0, 16'h8080);
        rd(4'h0, 16'h80a0, "software trigger clear");
        kind <= 2'h3;
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(4'h0, 16'h8080 | i[15:0]);
            wt(2, 1'b1);
            chk("input mode", {12'h0, lvl, skip, itm}, {12'h0, i[1:0], i[1:0]});
        end
        kind <= 2'h0;
        wt(2, 1'b1);
        chk("mode outside wait", {14'h0, itm}, 16'h0000);
        wr(4'h0, 16'h0100);
        for (i = 0; i < 5; i = i + 1)
            rd(4'h3 + i[3:0], nsteps[15:0] ^ (BASE + i[15:0]), "live value");
        wr(4'h0, 16'h0200);
        rd(4'h0, 16'h0000, "single step outside debug");
        dbg <= 1'b1;
        wr(4'h0, 16'h8280);
        rd(4'h0, 16'h82a0, "single step in debug");
        chk("unarmed step", {15'h0, adv}, 16'h0000);
        wr(4'h8, 16'h0001);
        wt(2, 1'b1);
        wr(4'h0, 16'h0000);
        wt(2, 1'b0);
        rd(4'h0, 16'h0000, "disabled state");
        step(2'h1);
        @(posedge clk);
        #1;
        chk("disabled trigger", {15'h0, trigger_output}, 16'h0000);
        report_and_stop;
    end
endmodule

// [tsc_engine_model.sv]
`timescale 1ns/1ps
// ==========
// step engine stand-in; live values only track finished steps, not real timers
module tsc_engine_model
#(
    parameter [15:0] BASE = 16'h0000
)
(
    input  wire        clk,
    input  wire        arst_n,
    input  wire [1:0]  kind,
    input  wire        go,
    input  wire [1:0]  pl,
    input  wire        advance,
    output reg         done_q,
    output reg  [1:0]  ev_q,
    output wire        is_trigger_output,
    output wire        is_swt,
    output wire        is_winp,
    output wire [79:0] live
);
    reg  [15:0] cnt_q;
    assign is_trigger_output = kind == 2'h1;
    assign is_swt  = kind == 2'h2;
    assign is_winp = kind == 2'h3;
    assign live    = {cnt_q ^ (BASE + 16'h4), cnt_q ^ (BASE + 16'h3), cnt_q ^ (BASE + 16'h2),
                      cnt_q ^ (BASE + 16'h1), cnt_q ^ BASE};
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            done_q <= 1'b0;
            ev_q   <= 2'h0;
            cnt_q  <= 16'h0000;
        end
        else
        begin
            done_q <= go & advance;
            ev_q   <= pl;
            cnt_q  <= cnt_q + {15'h0, done_q};
        end
    end
endmodule

// [tsc_regs.vh]
`ifndef TSC_REGS_VH
`define TSC_REGS_VH
// =====================================================================
// register offsets (word index on the plain port)
`define TSC_ADDR_CST        4'h0
`define TSC_ADDR_IRQ_STAT   4'h1
`define TSC_ADDR_IRQ_MASK   4'h2
`define TSC_ADDR_SDLY       4'h3
`define TSC_ADDR_LCNT0      4'h4
`define TSC_ADDR_LCNT1      4'h5
`define TSC_ADDR_GTMR0      4'h6
`define TSC_ADDR_GTMR1      4'h7
`define TSC_ADDR_DEBUG      4'h8
// =====================================================================
// control/status field positions
`define TSC_BIT_EN          15
`define TSC_BIT_IDLE_HALT   13
`define TSC_BIT_TOGGLE      12
`define TSC_BIT_SWT         10
`define TSC_BIT_SSEN        9
`define TSC_BIT_VIS         8
`define TSC_BIT_START       7
`define TSC_BIT_WDTO        6
`define TSC_BIT_BUSY        5
`define TSC_ITM_HI          1
`define TSC_ITM_LO          0
// =====================================================================
// reset values and masks
`define TSC_CST_RESET       16'h0000
`define TSC_CST_WMASK       16'hb783
`define TSC_IRQ_RESET       2'h0
`define TSC_LIM_RESET       16'h0000
// =====================================================================
// interrupt status bit positions
`define TSC_IRQ_WDTO        0
`define TSC_IRQ_TRIGGER_OUTPUT        1
// =====================================================================
// wait-for-software-trigger option codes
`define TSC_OPT_SWT_A       4'ha
`define TSC_OPT_SWT_B       4'hb
`endif
